//--- ccef_map.svh
`ifndef CCEF_MAP_SVH
`define CCEF_MAP_SVH

// register offsets
`define CCEF_OFS_ERR        8'h00
`define CCEF_OFS_CTRL       8'h01
`define CCEF_OFS_IRQ_STAT   8'h02
`define CCEF_OFS_IRQ_MASK   8'h03
`define CCEF_OFS_COLL_POS   8'h04

// error flag bit positions
`define CCEF_BIT_NVM        7
`define CCEF_BIT_FWMIS      6
`define CCEF_BIT_OVF        5
`define CCEF_BIT_SHORT      4
`define CCEF_BIT_EMPTY      3
`define CCEF_BIT_COLL       2
`define CCEF_BIT_PROT       1
`define CCEF_BIT_INTEG      0

// control register bit positions
`define CCEF_CTRL_COLL_ERR  0
`define CCEF_CTRL_MULTI     1
`define CCEF_CTRL_EMD       2

// flags that feed the error summary
`define CCEF_ERR_SUM_MASK   8'h6b
// flags cleared at start of reception
`define CCEF_RX_CLR_MASK    8'h17

// reset values
`define CCEF_RST_ERR        8'h00
`define CCEF_RST_CTRL       8'h00
`define CCEF_RST_MASK       8'h00

// transceiver state codes
`define CCEF_CS_IDLE        3'h0
`define CCEF_CS_TXWAIT      3'h1
`define CCEF_CS_TX          3'h3
`define CCEF_CS_RXWAIT      3'h5
`define CCEF_CS_WAITDATA    3'h6
`define CCEF_CS_RECEIVING   3'h7

// command kinds
`define CCEF_CMD_OTHER      2'h0
`define CCEF_CMD_RECEIVE    2'h1
`define CCEF_CMD_TRANSCEIVE 2'h2

// frame length and collision position thresholds
`define CCEF_MIN_BITS       5'h04
`define CCEF_MIN_EMD_BYTES  2'h3
`define CCEF_COLL_POS_LIMIT 7'h40

`endif

//--- ccef_pkg.sv
package ccef_pkg;

   typedef enum logic [1:0] {
      CCEF_RX_IDLE,
      CCEF_RX_FRAME,
      CCEF_RX_DRAIN
   } ccef_rx_state_t;

   typedef logic [7:0] ccef_byte_t;

endpackage

//--- ccef_error_flags.sv
`timescale 1ns/1ps
`include "ccef_map.svh"

module ccef_error_flags
   import ccef_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic [7:0]      reg_rdata,
   // command sequencer
   input  wire logic       cmd_start,
   input  wire logic [1:0] cmd_kind,
   input  wire logic       auth_active,
   input  wire logic [2:0] com_state,
   input  wire logic       crc_tx_phase,
   input  wire logic       tx_request,
   input  wire logic       frame_flags_written,
   // memory controller
   input  wire logic       nvm_cmd_done,
   input  wire logic       nvm_cmd_failed,
   // host FIFO write path
   input  wire logic       host_fifo_wr,
   input  wire logic [7:0] host_fifo_data,
   input  wire logic       fifo_full,
   input  wire logic       fifo_empty,
   input  wire logic       fifo_flush,
   output logic            host_fifo_we,
   output logic [7:0]      host_fifo_wd,
   // receive decoder
   input  wire logic       rx_sof,
   input  wire logic       rx_bit,
   input  wire logic       rx_byte,
   input  wire logic [7:0] rx_byte_data,
   input  wire logic       rx_frame_end,
   input  wire logic       rx_coll,
   input  wire logic       rx_coll_in_eof,
   input  wire logic [6:0] rx_coll_pos,
   input  wire logic       rx_stop_err,
   input  wire logic       rx_sof_err,
   input  wire logic       rx_count_err,
   input  wire logic       rx_parity_err,
   input  wire logic       rx_crc_err,
   // receive side results
   output logic            rx_fifo_we,
   output logic [7:0]      rx_fifo_wd,
   output logic            receive_done_irq,
   output logic            receive_decoder_rearm,
   output logic            receive_decoder_halt,
   // interrupts
   output logic            error_summary_irq,
   output logic            irq
);

   ccef_byte_t      err_r;
   ccef_byte_t      err_nxt;
   ccef_byte_t      err_prev_r;
   ccef_byte_t      ctrl_r;
   ccef_byte_t      irq_stat_r;
   ccef_byte_t      irq_mask_r;
   ccef_byte_t      coll_pos_r;
   ccef_byte_t      rdata_r;
   ccef_byte_t      hold_r [0:2];
   logic [1:0]      hold_cnt_r;
   logic [1:0]      byte_cnt_r;
   logic [4:0]      bit_cnt_r;
   ccef_rx_state_t  rx_state_r;
   logic            xcv_pending_r;
   logic            multi_clear_pending_r;
   logic [2:0]      com_state_prev_r;
   logic            host_we_r;
   ccef_byte_t      host_wd_r;
   logic            rx_we_r;
   ccef_byte_t      rx_wd_r;
   logic            rx_done_r;
   logic            rearm_r;
   logic            halt_r;
   logic            err_irq_r;
   logic            irq_r;

   logic            wr_err;
   logic            wr_ctrl;
   logic            wr_irq_stat;
   logic            wr_irq_mask;
   logic            rx_clear;
   logic            host_misuse;
   logic            any_write;
   logic            write_blocked;
   logic            prot_event;
   logic            integ_event;
   logic            coll_event;
   logic            frame_short;
   logic            frame_emd_short;
   logic            rx_push_req;
   logic            release_one;
   logic [1:0]      keep_cnt;

   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
      addr_hit = (a == ofs);
   endfunction

   function automatic logic in_receive_state(input logic [2:0] cs);
      in_receive_state = (cs == `CCEF_CS_RXWAIT) || (cs == `CCEF_CS_WAITDATA) ||
                         (cs == `CCEF_CS_RECEIVING);
   endfunction

   // register decode; the error register is read only
   assign wr_err      = reg_wr && addr_hit(reg_addr, `CCEF_OFS_ERR);
   assign wr_ctrl     = reg_wr && addr_hit(reg_addr, `CCEF_OFS_CTRL);
   assign wr_irq_stat = reg_wr && addr_hit(reg_addr, `CCEF_OFS_IRQ_STAT);
   assign wr_irq_mask = reg_wr && addr_hit(reg_addr, `CCEF_OFS_IRQ_MASK);

   // receive flags clear on a receive start or on entering wait-for-data of a transceive
   assign rx_clear = (cmd_start && (cmd_kind == `CCEF_CMD_RECEIVE)) ||
                     (xcv_pending_r && (com_state == `CCEF_CS_WAITDATA) &&
                      (com_state_prev_r != `CCEF_CS_WAITDATA));

   assign host_misuse = host_fifo_wr &&
                        (crc_tx_phase || in_receive_state(com_state) || auth_active);

   assign rx_push_req   = (rx_state_r != CCEF_RX_IDLE) && release_one;
   assign any_write     = (host_fifo_wr && !host_misuse) || rx_push_req;
   assign write_blocked = fifo_full || err_r[`CCEF_BIT_OVF];

   assign prot_event  = (rx_state_r == CCEF_RX_FRAME) &&
                        (rx_stop_err || rx_sof_err || rx_count_err);
   assign coll_event  = (rx_state_r == CCEF_RX_FRAME) && rx_coll && !rx_coll_in_eof;
   assign integ_event = (rx_state_r == CCEF_RX_FRAME) &&
                        (rx_parity_err || rx_crc_err ||
                         (coll_event && ctrl_r[`CCEF_CTRL_COLL_ERR]));

   assign frame_short     = (bit_cnt_r < `CCEF_MIN_BITS);
   assign frame_emd_short = ctrl_r[`CCEF_CTRL_EMD] && (byte_cnt_r < `CCEF_MIN_EMD_BYTES);

   // with suppression on, two bytes stay held until the third proves the frame long enough
   assign keep_cnt    = (ctrl_r[`CCEF_CTRL_EMD] && (byte_cnt_r < `CCEF_MIN_EMD_BYTES)) ?
                        2'h2 : 2'h1;
   assign release_one = (rx_state_r == CCEF_RX_DRAIN) ? (hold_cnt_r != 2'h0) :
                        (hold_cnt_r > keep_cnt);

   // error flags: every set wins over a clear in the same cycle
   always_comb begin
      err_nxt = err_r;
      if (nvm_cmd_done) begin
         err_nxt[`CCEF_BIT_NVM] = nvm_cmd_failed;
      end
      if (cmd_start && !ctrl_r[`CCEF_CTRL_MULTI]) begin
         err_nxt[`CCEF_BIT_FWMIS] = 1'b0;
      end
      if (multi_clear_pending_r && frame_flags_written) begin
         err_nxt[`CCEF_BIT_FWMIS] = 1'b0;
      end
      if (cmd_start || fifo_flush) begin
         err_nxt[`CCEF_BIT_EMPTY] = 1'b0;
      end
      if (fifo_flush) begin
         err_nxt[`CCEF_BIT_OVF] = 1'b0;
      end
      if (rx_clear) begin
         err_nxt = err_nxt & ~`CCEF_RX_CLR_MASK;
      end
      if (host_misuse) begin
         err_nxt[`CCEF_BIT_FWMIS] = 1'b1;
      end
      if (any_write && fifo_full) begin
         err_nxt[`CCEF_BIT_OVF] = 1'b1;
      end
      if ((rx_state_r == CCEF_RX_FRAME) && rx_frame_end && frame_short) begin
         err_nxt[`CCEF_BIT_SHORT] = 1'b1;
      end
      if (tx_request && fifo_empty) begin
         err_nxt[`CCEF_BIT_EMPTY] = 1'b1;
      end
      if (coll_event) begin
         err_nxt[`CCEF_BIT_COLL] = 1'b1;
      end
      if (prot_event) begin
         err_nxt[`CCEF_BIT_PROT] = 1'b1;
      end
      if (integ_event) begin
         err_nxt[`CCEF_BIT_INTEG] = 1'b1;
      end
   end

   // flags only move on their own events; reads never touch them
   always_ff @(posedge mclk) begin
      if (rst) begin
         err_r      <= `CCEF_RST_ERR;
         err_prev_r <= `CCEF_RST_ERR;
      end else begin
         err_r      <= err_nxt;
         err_prev_r <= err_r;
      end
   end

   // software controls
   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_r     <= `CCEF_RST_CTRL;
         irq_mask_r <= `CCEF_RST_MASK;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= reg_wdata & 8'h07;
         end
         if (wr_irq_mask) begin
            irq_mask_r <= reg_wdata;
         end
      end
   end

   // sticky interrupt status: rising flag sets, write-one clears, set wins
   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_stat_r <= 8'h00;
      end else begin
         irq_stat_r <= (irq_stat_r & ~(wr_irq_stat ? reg_wdata : 8'h00)) |
                       (err_r & ~err_prev_r);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_r     <= 1'b0;
         err_irq_r <= 1'b0;
      end else begin
         irq_r     <= |(irq_stat_r & irq_mask_r);
         err_irq_r <= |(err_nxt & `CCEF_ERR_SUM_MASK);
      end
   end

   // transceive tracking and deferred misuse clear
   always_ff @(posedge mclk) begin
      if (rst) begin
         xcv_pending_r         <= 1'b0;
         multi_clear_pending_r <= 1'b0;
         com_state_prev_r      <= `CCEF_CS_IDLE;
      end else begin
         com_state_prev_r <= com_state;
         if (cmd_start) begin
            xcv_pending_r <= (cmd_kind == `CCEF_CMD_TRANSCEIVE);
         end else if (rx_clear) begin
            xcv_pending_r <= 1'b0;
         end
         if (cmd_start && ctrl_r[`CCEF_CTRL_MULTI]) begin
            multi_clear_pending_r <= 1'b1;
         end else if (frame_flags_written) begin
            multi_clear_pending_r <= 1'b0;
         end
      end
   end

   // first collision position, valid only inside the first eight bytes
   always_ff @(posedge mclk) begin
      if (rst) begin
         coll_pos_r <= 8'h00;
      end else if (coll_event && (!err_r[`CCEF_BIT_COLL] || rx_clear)) begin
         coll_pos_r <= {(rx_coll_pos < `CCEF_COLL_POS_LIMIT), rx_coll_pos};
      end else if (rx_clear) begin
         coll_pos_r <= 8'h00;
      end
   end

   // host FIFO write forwarding
   always_ff @(posedge mclk) begin
      if (rst) begin
         host_we_r <= 1'b0;
         host_wd_r <= 8'h00;
      end else begin
         host_we_r <= host_fifo_wr && !host_misuse && !write_blocked;
         host_wd_r <= host_fifo_data;
      end
   end

   // frame sequencing
   always_ff @(posedge mclk) begin
      if (rst) begin
         rx_state_r <= CCEF_RX_IDLE;
         bit_cnt_r  <= 5'h00;
         byte_cnt_r <= 2'h0;
         rx_done_r  <= 1'b0;
         rearm_r    <= 1'b0;
         halt_r     <= 1'b0;
      end else begin
         rx_done_r <= 1'b0;
         rearm_r   <= 1'b0;
         halt_r    <= 1'b0;
         unique case (rx_state_r)
            CCEF_RX_IDLE: begin
               if (rx_sof) begin
                  rx_state_r <= CCEF_RX_FRAME;
                  bit_cnt_r  <= 5'h00;
                  byte_cnt_r <= 2'h0;
               end
            end
            CCEF_RX_FRAME: begin
               if (rx_bit && (bit_cnt_r != 5'h1f)) begin
                  bit_cnt_r <= bit_cnt_r + 5'h01;
               end
               if (rx_byte && (byte_cnt_r != 2'h3)) begin
                  byte_cnt_r <= byte_cnt_r + 2'h1;
               end
               if (prot_event) begin
                  halt_r     <= 1'b1;
                  rx_state_r <= CCEF_RX_DRAIN;
               end else if (rx_frame_end) begin
                  if (frame_short || frame_emd_short) begin
                     rearm_r    <= 1'b1;
                     rx_state_r <= CCEF_RX_IDLE;
                  end else begin
                     rx_done_r  <= 1'b1;
                     rx_state_r <= CCEF_RX_DRAIN;
                  end
               end
            end
            CCEF_RX_DRAIN: begin
               if (hold_cnt_r <= 2'h1) begin
                  rx_state_r <= CCEF_RX_IDLE;
               end
            end
         endcase
      end
   end

   // received bytes wait in a short hold queue so a failed frame can be withheld
   always_ff @(posedge mclk) begin
      if (rst) begin
         hold_cnt_r <= 2'h0;
         hold_r[0]  <= 8'h00;
         hold_r[1]  <= 8'h00;
         hold_r[2]  <= 8'h00;
         rx_we_r    <= 1'b0;
         rx_wd_r    <= 8'h00;
      end else begin
         rx_we_r <= rx_push_req && !write_blocked;
         rx_wd_r <= hold_r[0];
         // shift first so that a byte stored in the same cycle is not overwritten
         if (release_one && !(prot_event && (hold_cnt_r == 2'h1))) begin
            hold_r[0] <= hold_r[1];
            hold_r[1] <= hold_r[2];
         end
         if ((rx_state_r == CCEF_RX_IDLE) || ((rx_state_r == CCEF_RX_FRAME) &&
             rx_frame_end && !prot_event && (frame_short || frame_emd_short))) begin
            hold_cnt_r <= 2'h0;
         end else if (prot_event) begin
            hold_cnt_r <= (hold_cnt_r > {1'b0, release_one}) ?
                          hold_cnt_r - {1'b0, release_one} - 2'h1 : 2'h0;
         end else if ((rx_state_r == CCEF_RX_FRAME) && rx_byte && (hold_cnt_r != 2'h3)) begin
            hold_r[hold_cnt_r - (release_one ? 2'h1 : 2'h0)] <= rx_byte_data;
            hold_cnt_r <= hold_cnt_r + (release_one ? 2'h0 : 2'h1);
         end else if (release_one) begin
            hold_cnt_r <= hold_cnt_r - 2'h1;
         end
      end
   end

   // read data one cycle after the strobe; unmapped reads return zero
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata_r <= 8'h00;
      end else if (reg_rd) begin
         unique case (1'b1)
            addr_hit(reg_addr, `CCEF_OFS_ERR):      rdata_r <= err_r;
            addr_hit(reg_addr, `CCEF_OFS_CTRL):     rdata_r <= ctrl_r;
            addr_hit(reg_addr, `CCEF_OFS_IRQ_STAT): rdata_r <= irq_stat_r;
            addr_hit(reg_addr, `CCEF_OFS_IRQ_MASK): rdata_r <= irq_mask_r;
            addr_hit(reg_addr, `CCEF_OFS_COLL_POS): rdata_r <= coll_pos_r;
            default:                                rdata_r <= 8'h00;
         endcase
      end else begin
         rdata_r <= 8'h00;
      end
   end

   assign reg_rdata             = rdata_r;
   assign host_fifo_we          = host_we_r;
   assign host_fifo_wd          = host_wd_r;
   assign rx_fifo_we            = rx_we_r;
   assign rx_fifo_wd            = rx_wd_r;
   assign receive_done_irq      = rx_done_r;
   assign receive_decoder_rearm = rearm_r;
   assign receive_decoder_halt  = halt_r;
   assign error_summary_irq     = err_irq_r;
   assign irq                   = irq_r;

endmodule // ccef_error_flags

//--- ccef_flags_chk_sva.sv
`timescale 1ns/1ps
`include "ccef_map.svh"
module ccef_flags_chk (
   // clock and reset
   input wire logic       mclk,
   input wire logic       rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   // sequencer and fifo
   input wire logic       cmd_start,
   input wire logic       auth_active,
   input wire logic [2:0] com_state,
   input wire logic       crc_tx_phase,
   input wire logic       tx_request,
   input wire logic       frame_flags_written,
   input wire logic       host_fifo_wr,
   input wire logic [7:0] host_fifo_data,
   input wire logic       fifo_full,
   input wire logic       fifo_empty,
   input wire logic       fifo_flush,
   input wire logic       host_fifo_we,
   input wire logic [7:0] host_fifo_wd,
   // decoder events
   input wire logic       rx_coll,
   input wire logic       rx_stop_err,
   input wire logic       rx_sof_err,
   input wire logic       rx_count_err,
   input wire logic       rx_parity_err,
   input wire logic       rx_crc_err,
   // results
   input wire logic       receive_done_irq,
   input wire logic       receive_decoder_rearm,
   input wire logic       receive_decoder_halt,
   input wire logic       error_summary_irq,
   input wire logic       irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic misuse;
   assign misuse = auth_active | crc_tx_phase | (com_state >= 3'h5);
   misuse_drop_a: assert property (host_fifo_wr && misuse |=> error_summary_irq && !host_fifo_we)
      else $error("misuse write not flagged or not dropped");
   ovf_drop_a: assert property (host_fifo_wr && fifo_full |=> error_summary_irq && !host_fifo_we)
      else $error("write into full fifo not flagged or not dropped");
   wd_pass_a: assert property (host_fifo_we |-> host_fifo_wd == $past(host_fifo_data))
      else $error("fifo write data altered");
   empty_tx_a: assert property (tx_request && fifo_empty |=> error_summary_irq)
      else $error("empty transmit not flagged");
   halt_flag_a: assert property (receive_decoder_halt |-> error_summary_irq)
      else $error("halt without protocol flag");
   rearm_quiet_a: assert property (receive_decoder_rearm |-> !receive_done_irq)
      else $error("dropped frame raised receive done");
   // any clear source excuses a drop, so this only catches spontaneous loss
   flag_hold_a: assert property (error_summary_irq && !cmd_start && !fifo_flush
      && !frame_flags_written && com_state != 3'h6 |=> error_summary_irq)
      else $error("error summary dropped without clear");
   sum_cause_a: assert property ($rose(error_summary_irq) |-> $past(host_fifo_wr | tx_request
      | rx_stop_err | rx_sof_err | rx_count_err | rx_parity_err | rx_crc_err | rx_coll | fifo_full))
      else $error("error summary rose without cause");
   mask_off_a: assert property (reg_wr && reg_addr == `CCEF_OFS_IRQ_MASK && reg_wdata == 8'h00
      |=> ##1 !irq)
      else $error("irq high with mask cleared");
   cover property (receive_done_irq);
   cover property (receive_decoder_rearm);
   cover property (receive_decoder_halt);
   cover property (irq);
endmodule // ccef_flags_chk
bind ccef_error_flags ccef_flags_chk chk_u (.*);

//--- ccef_card_model.sv
`timescale 1ns/1ps
module ccef_card_model (
   // clock
   input  wire logic mclk,
   // decoder events toward the block
   output logic       rx_sof,
   output logic       rx_bit,
   output logic       rx_byte,
   output logic [7:0] rx_byte_data,
   output logic       rx_frame_end,
   output logic       rx_coll,
   output logic       rx_coll_in_eof,
   output logic [6:0] rx_coll_pos,
   output logic       rx_stop_err,
   output logic       rx_sof_err,
   output logic       rx_count_err,
   output logic       rx_parity_err,
   output logic       rx_crc_err
);
   // event k stands alone; any other k lowers every event
   task automatic set_events(input int k);
      rx_sof <= (k == 0);
      rx_bit <= (k == 1);
      rx_byte <= (k == 2);
      rx_frame_end <= (k == 3);
      rx_coll <= (k == 4);
      rx_stop_err <= (k == 5);
      rx_sof_err <= (k == 6);
      rx_count_err <= (k == 7);
      rx_parity_err <= (k == 8);
      rx_crc_err <= (k == 9);
   endtask
   // qualifiers show inverted data between strobes so late sampling cannot pass
   initial begin
      rx_byte_data = 8'hff;
      rx_coll_pos = 7'h7f;
      rx_coll_in_eof = 1'b1;
      set_events(-1);
   end
   task automatic pulse(input int k);
      set_events(k);
      @(posedge mclk);
      set_events(-1);
      @(posedge mclk);
   endtask
   // gap gives a slow card between bytes
   task automatic bytes(input int n, input logic [7:0] b0, input int gap);
      for (int i = 0; i < n; i++) begin
         repeat (8) pulse(1);
         rx_byte_data <= b0 + 8'(i);
         pulse(2);
         rx_byte_data <= ~(b0 + 8'(i));
         repeat (gap) @(posedge mclk);
      end
   endtask
   task automatic coll(input logic [6:0] p, input logic in_eof);
      rx_coll_pos <= p;
      rx_coll_in_eof <= in_eof;
      pulse(4);
      rx_coll_pos <= ~p;
      rx_coll_in_eof <= ~in_eof;
   endtask
endmodule // ccef_card_model

//--- ccef_error_flags_tb.sv
`timescale 1ns/1ps
`include "ccef_map.svh"
module ccef_error_flags_tb;
   import ccef_pkg::*;
   localparam logic [7:0] ERR = `CCEF_OFS_ERR, CTRL = `CCEF_OFS_CTRL;
   localparam logic [7:0] STAT = `CCEF_OFS_IRQ_STAT, MASK = `CCEF_OFS_IRQ_MASK;
   logic mclk, rst, reg_wr, reg_rd, auth_active, crc_tx_phase, nvm_cmd_failed;
   logic fifo_full, fifo_empty, cmd_start, tx_request, frame_flags_written;
   logic nvm_cmd_done, host_fifo_wr, fifo_flush, host_fifo_we, rx_fifo_we, irq;
   logic receive_done_irq, receive_decoder_rearm, receive_decoder_halt, error_summary_irq;
   logic rx_sof, rx_bit, rx_byte, rx_frame_end, rx_coll, rx_coll_in_eof, rx_stop_err;
   logic rx_sof_err, rx_count_err, rx_parity_err, rx_crc_err;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, host_fifo_data, host_fifo_wd;
   logic [7:0] rx_byte_data, rx_fifo_wd, last_wd;
   logic [6:0] rx_coll_pos;
   logic [2:0] com_state;
   logic [1:0] cmd_kind;
   logic [7:0] q[$];
   int errors = 0, n_tests = 0, n_hwe = 0, n_done = 0, n_rearm = 0, n_halt = 0;
   ccef_error_flags dut_u (.*);
   ccef_card_model card_u (.*);
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (rx_fifo_we) q.push_back(rx_fifo_wd);
      if (receive_done_irq) n_done++;
      if (receive_decoder_rearm) n_rearm++;
      if (receive_decoder_halt) n_halt++;
      if (host_fifo_we) begin
         n_hwe++;
         last_wd = host_fifo_wd;
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask
   // data stands only in the cycle after the strobe: sampled at that cycle's end
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      chk(reg_rdata, e);
   endtask
   task automatic set_strobes(input int k);
      cmd_start <= (k == 0);
      tx_request <= (k == 1);
      frame_flags_written <= (k == 2);
      nvm_cmd_done <= (k == 3);
      host_fifo_wr <= (k == 4);
      fifo_flush <= (k == 5);
   endtask
   task automatic pls(input int k);
      set_strobes(k);
      @(posedge mclk);
      set_strobes(-1);
      @(posedge mclk);
   endtask
   task automatic cmd(input logic [1:0] k);
      cmd_kind <= k;
      pls(0);
   endtask
   task automatic hw(input logic [7:0] d);
      host_fifo_data <= d;
      pls(4);
   endtask
   task automatic expect_q(input logic [7:0] b0, input int n);
      chk(8'(q.size()), 8'(n));
      foreach (q[i]) chk(q[i], b0 + 8'(i));
      q.delete();
   endtask
   task automatic frame(input int n, input logic [7:0] b0, input int gap);
      card_u.pulse(0);
      card_u.bytes(n, b0, gap);
      card_u.pulse(3);
      idle(8);
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // whole sequence needs about 700 cycles
   initial begin
      #500000;
      errors++;
      conclude();
   end
   initial begin
      {reg_addr, reg_wdata, reg_wr, reg_rd, cmd_kind, auth_active, com_state} = '0;
      {crc_tx_phase, nvm_cmd_failed, host_fifo_data, fifo_full, fifo_empty} = '0;
      set_strobes(-1);
      rst = 1'b1;
      idle(6);
      rst <= 1'b0;
      idle(1);
      rd(ERR, `CCEF_RST_ERR);
      rd(CTRL, `CCEF_RST_CTRL);
      rd(MASK, `CCEF_RST_MASK);
      rd(8'hff, 8'h00);
      wr(CTRL, 8'h07);
      rd(CTRL, 8'h07);
      wr(ERR, 8'hff);
      rd(ERR, 8'h00);
      wr(CTRL, 8'h00);
      nvm_cmd_failed <= 1'b1;
      pls(3);
      rd(ERR, 8'h80);
      rd(ERR, 8'h80);
      nvm_cmd_failed <= 1'b0;
      pls(3);
      rd(ERR, 8'h00);
      hw(8'h5a);
      idle(2);
      chk(last_wd, 8'h5a);
      for (int m = 0; m < 5; m++) begin
         com_state <= (m < 3) ? 3'(5 + m) : 3'h0;
         crc_tx_phase <= (m == 3);
         auth_active <= (m == 4);
         hw(8'h11);
         {com_state, crc_tx_phase, auth_active} <= '0;
         idle(2);
         chk(8'(n_hwe), 8'h01);
         rd(ERR, 8'h40);
         cmd(`CCEF_CMD_OTHER);
         rd(ERR, 8'h00);
      end
      wr(CTRL, 8'h02);
      auth_active <= 1'b1;
      hw(8'h22);
      auth_active <= 1'b0;
      cmd(`CCEF_CMD_OTHER);
      rd(ERR, 8'h40);
      pls(2);
      rd(ERR, 8'h00);
      wr(CTRL, 8'h00);
      fifo_full <= 1'b1;
      hw(8'h33);
      fifo_full <= 1'b0;
      hw(8'h44);
      idle(2);
      chk(8'(n_hwe), 8'h01);
      rd(ERR, 8'h20);
      pls(5);
      hw(8'h55);
      idle(2);
      chk(last_wd, 8'h55);
      fifo_empty <= 1'b1;
      pls(1);
      fifo_empty <= 1'b0;
      rd(ERR, 8'h08);
      rd(STAT, 8'he8);
      chk({7'h0, irq}, 8'h00);
      wr(MASK, 8'h08);
      idle(2);
      chk({6'h0, irq, error_summary_irq}, 8'h03);
      wr(STAT, 8'h08);
      idle(2);
      chk({7'h0, irq}, 8'h00);
      cmd(`CCEF_CMD_OTHER);
      rd(ERR, 8'h00);
      wr(MASK, 8'h00);
      cmd(`CCEF_CMD_RECEIVE);
      frame(2, 8'ha0, 0);
      expect_q(8'ha0, 2);
      for (int k = 3; k < 5; k++) begin
         card_u.pulse(0);
         repeat (k) card_u.pulse(1);
         card_u.pulse(3);
         idle(4);
      end
      chk(8'(n_rearm), 8'h01);
      chk(8'(n_done), 8'h02);
      rd(ERR, 8'h10);
      cmd(`CCEF_CMD_RECEIVE);
      rd(ERR, 8'h00);
      wr(CTRL, 8'h04);
      for (int n = 2; n < 4; n++) frame(n, 8'hb0, n);
      expect_q(8'hb0, 3);
      chk(8'(n_rearm), 8'h02);
      chk(8'(n_done), 8'h03);
      wr(CTRL, 8'h00);
      for (int k = 5; k < 8; k++) begin
         cmd(`CCEF_CMD_RECEIVE);
         card_u.pulse(0);
         card_u.bytes(2, 8'hc0, 0);
         card_u.pulse(k);
         idle(8);
         expect_q(8'hc0, 1);
         rd(ERR, 8'h02);
      end
      chk(8'(n_halt), 8'h03);
      cmd(`CCEF_CMD_RECEIVE);
      card_u.pulse(0);
      card_u.bytes(1, 8'hd0, 0);
      card_u.pulse(8);
      card_u.pulse(9);
      frame(1, 8'hd1, 0);
      expect_q(8'hd0, 2);
      rd(ERR, 8'h01);
      cmd(`CCEF_CMD_RECEIVE);
      card_u.pulse(0);
      card_u.bytes(1, 8'he0, 0);
      card_u.coll(7'h05, 1'b0);
      card_u.coll(7'h09, 1'b0);
      card_u.pulse(3);
      rd(ERR, 8'h04);
      rd(`CCEF_OFS_COLL_POS, 8'h85);
      cmd(`CCEF_CMD_RECEIVE);
      card_u.pulse(0);
      card_u.bytes(1, 8'he0, 0);
      card_u.coll(7'h03, 1'b1);
      card_u.pulse(3);
      rd(ERR, 8'h00);
      wr(CTRL, 8'h01);
      card_u.pulse(0);
      card_u.bytes(1, 8'he0, 0);
      card_u.coll(7'h02, 1'b0);
      card_u.pulse(3);
      rd(ERR, 8'h05);
      cmd(`CCEF_CMD_TRANSCEIVE);
      rd(ERR, 8'h05);
      com_state <= 3'h6;
      idle(2);
      rd(ERR, 8'h00);
      com_state <= 3'h0;
      q.delete();
      conclude();
   end
endmodule // ccef_error_flags_tb
